// >>> core/lcdc_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_clkgen (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic fsub_in,
	input wire logic scan_run,
	input wire logic pump_run,
	input wire logic [2:0] pump_div,
	output logic lcd_tick,
	output logic c_pump_clk
);
	import lcdc_pkg::*;

	logic fsub_q_r;
	logic fsub_rise;
	logic [2:0] div_r;
	logic tick_r;
	logic [6:0] pump_cnt_r;
	logic pump_clk_r;
	logic [6:0] pump_half;
	logic [2:0] pump_code;

	// Sub-clock is slow enough to edge-detect on ref_clk
	assign fsub_rise = fsub_in & ~fsub_q_r;
	// Code 111 behaves as 110
	assign pump_code = (pump_div > PUMP_CODE_LAST) ? PUMP_CODE_LAST : pump_div;
	assign pump_half = PUMP_HALF_MAX >> pump_code;

	// No reset: a cleared copy would fake a rise if the sub-clock is high
	always_ff @(posedge ref_clk) begin
		fsub_q_r <= fsub_in;
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !scan_run) begin
			div_r <= 3'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= fsub_rise && (div_r == LCD_DIV_LAST);
			if (fsub_rise) begin
				div_r <= div_r + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !pump_run) begin
			pump_cnt_r <= 7'h00;
			pump_clk_r <= 1'b0;
		end else if (fsub_rise) begin
			if (pump_cnt_r >= pump_half - 7'h01) begin
				pump_cnt_r <= 7'h00;
				pump_clk_r <= ~pump_clk_r;
			end else begin
				pump_cnt_r <= pump_cnt_r + 7'h01;
			end
		end
	end

	assign lcd_tick = tick_r;
	assign c_pump_clk = pump_clk_r;
endmodule : lcdc_clkgen
`default_nettype wire

// >>> core/lcdc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_ctrl #(
	parameter int unsigned NUM_SEG = 44
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire lcdc_pkg::lcdc_mode_t op_mode,
	input wire logic fsub_in,
	input wire logic [2:0] dm_sector,
	input wire logic dm_sel,
	input wire logic sfr_sel,
	input wire logic [7:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic [23:0] com_lvl,
	output logic [7:0] com_oe_n,
	output logic [3*NUM_SEG-1:0] seg_lvl,
	output logic [NUM_SEG-1:0] seg_oe_n,
	output logic lcd_active,
	output logic waveform_type_b,
	output logic bias_scheme_c,
	output logic [1:0] c_power_source_sel,
	output logic [1:0] r_bias_current_sel,
	output logic r_supply_internal,
	output logic r_pump_en,
	output logic [1:0] r_pump_voltage_sel,
	output logic c_pump_en,
	output logic c_pump_clk,
	output logic bias_quarter,
	output logic [3:0] com_count
);
	import lcdc_pkg::*;

	localparam int unsigned AW = $clog2(NUM_SEG);
	localparam logic [7:0] DM_DEPTH = 8'(NUM_SEG);

	if (NUM_SEG < 2 || NUM_SEG > SEG_MAX) begin : g_bad_seg
		$error("lcdc_ctrl: NUM_SEG out of range");
	end

	logic [7:0] main_ctl_r;
	logic [7:0] pump_sel_r;
	logic [7:0] clk_duty_r;
	logic [7:0] disp_mem [NUM_SEG];
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	logic waveform_type;
	logic bias_scheme_sel;
	logic display_enable;
	logic r_supply_sel;
	logic [2:0] c_pump_clock_div;
	logic [1:0] duty_sel;
	logic bias_bit;

	logic lcd_on;
	logic [3:0] com_n;
	logic [7:0] com_mask;
	logic quarter_eff;
	logic dm_hit;
	logic sfr_wr;
	logic lcd_tick;

	logic [2:0] slot_r;
	logic half_r;
	logic pol_r;
	logic slot_last;
	logic polarity;
	logic [NUM_SEG-1:0] seg_on;
	logic [23:0] com_lvl_r;
	logic [3*NUM_SEG-1:0] seg_lvl_r;
	logic [7:0] com_oe_n_r;
	logic [NUM_SEG-1:0] seg_oe_n_r;

	// Level code k means k/N of the panel supply, N = 3 or 4
	function automatic logic [2:0] level_of(
		input logic is_com,
		input logic active,
		input logic neg,
		input logic quarter
	);
		logic [2:0] top;
		top = quarter ? 3'h4 : 3'h3;
		if (is_com) begin
			if (!neg) begin
				level_of = active ? top : 3'h1;
			end else begin
				level_of = active ? 3'h0 : top - 3'h1;
			end
		end else begin
			if (!neg) begin
				level_of = active ? 3'h0 : 3'h2;
			end else begin
				level_of = active ? top : top - 3'h2;
			end
		end
	endfunction : level_of

	// Control registers sit at small indices on the register select
	function automatic logic sfr_is(input logic [7:0] a, input logic [1:0] idx);
		sfr_is = (a == {6'h00, idx});
	endfunction : sfr_is

	assign waveform_type = main_ctl_r[MC_TYPE_BIT];
	assign bias_scheme_sel = main_ctl_r[MC_RCT_BIT];
	assign display_enable = main_ctl_r[MC_EN_BIT];
	assign r_supply_sel = pump_sel_r[PS_RSUP_BIT];
	assign c_pump_clock_div = clk_duty_r[CD_PCK_LSB +: 3];
	assign duty_sel = clk_duty_r[CD_DUTY_LSB +: 2];
	assign bias_bit = clk_duty_r[CD_BIAS_BIT];

	// Sleep overrides the enable bit
	assign lcd_on = display_enable && (op_mode != MODE_SLEEP);
	// Eight-COM request under C bias and the unimplemented code fall back
	assign com_n = lcdc_com_count(duty_sel, bias_scheme_sel);
	assign com_mask = lcdc_com_mask(com_n);
	// Quarter bias honoured only where it is legal
	assign quarter_eff = bias_bit && !bias_scheme_sel && (com_n == 4'h8);

	assign dm_hit = dm_sel && (dm_sector == DM_SECTOR) && (addr < DM_DEPTH);
	assign sfr_wr = sfr_sel && wr_en;

	// Register writes; unimplemented bits never stored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			main_ctl_r <= MC_RESET;
		end else if (sfr_wr && sfr_is(addr, REG_MAIN_IDX)) begin
			main_ctl_r <= wdata & MC_WMASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pump_sel_r <= PS_RESET;
		end else if (sfr_wr && sfr_is(addr, REG_PUMP_IDX)) begin
			pump_sel_r <= wdata & PS_WMASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_duty_r <= CD_RESET;
		end else if (sfr_wr && sfr_is(addr, REG_CLKDUTY_IDX)) begin
			clk_duty_r <= wdata & CD_WMASK;
		end
	end

	// Display memory keeps its contents through reset, like ordinary RAM
	always_ff @(posedge ref_clk) begin
		if (wr_en && dm_hit) begin
			disp_mem[addr[AW-1:0]] <= wdata & com_mask;
		end
	end

	// Read path; masking again covers a duty change after the write
	always_comb begin
		rdata_nxt = 8'h00;
		if (dm_hit) begin
			rdata_nxt = disp_mem[addr[AW-1:0]] & com_mask;
		end else if (sfr_sel) begin
			case (addr)
				{6'h00, REG_MAIN_IDX}: rdata_nxt = main_ctl_r;
				{6'h00, REG_PUMP_IDX}: rdata_nxt = pump_sel_r;
				{6'h00, REG_CLKDUTY_IDX}: rdata_nxt = clk_duty_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (rd_en) begin
			rdata_r <= rdata_nxt;
		end
	end

	lcdc_clkgen u_clkgen (
		.ref_clk(ref_clk),
		.rst(rst),
		.fsub_in(fsub_in),
		.scan_run(lcd_on),
		.pump_run(c_pump_en),
		.pump_div(c_pump_clock_div),
		.lcd_tick(lcd_tick),
		.c_pump_clk(c_pump_clk)
	);

	// Greater-or-equal guards against a duty shrink mid-frame
	assign slot_last = (slot_r >= 3'(com_n - 4'h1));
	assign polarity = waveform_type ? pol_r : half_r;

	// Slot sequencer: Type A flips polarity inside each slot,
	// Type B once per frame, with each slot one tick long instead of two
	always_ff @(posedge ref_clk) begin
		if (rst || !lcd_on) begin
			slot_r <= 3'h0;
			half_r <= 1'b0;
			pol_r <= 1'b0;
		end else if (lcd_tick) begin
			if (!waveform_type) begin
				half_r <= ~half_r;
				if (half_r) begin
					slot_r <= slot_last ? 3'h0 : slot_r + 3'h1;
				end
			end else begin
				half_r <= 1'b0;
				slot_r <= slot_last ? 3'h0 : slot_r + 3'h1;
				if (slot_last) begin
					pol_r <= ~pol_r;
				end
			end
		end
	end

	// Memory is sampled live every cycle, no software handshake
	for (genvar i = 0; i < NUM_SEG; i++) begin : g_seg
		assign seg_on[i] = disp_mem[i][slot_r];

		always_ff @(posedge ref_clk) begin
			if (rst || !lcd_on) begin
				seg_lvl_r[3*i +: 3] <= 3'h0;
			end else begin
				seg_lvl_r[3*i +: 3] <= level_of(1'b0, seg_on[i], polarity, quarter_eff);
			end
		end
	end

	for (genvar k = 0; k < 8; k++) begin : g_com
		always_ff @(posedge ref_clk) begin
			if (rst || !lcd_on || k >= com_n) begin
				com_lvl_r[3*k +: 3] <= 3'h0;
			end else begin
				com_lvl_r[3*k +: 3] <= level_of(1'b1, slot_r == 3'(k), polarity, quarter_eff);
			end
		end
	end

	// Chip reset floats the pins; unused COMs are left to the pin mux
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			com_oe_n_r <= 8'hFF;
			seg_oe_n_r <= '1;
		end else begin
			com_oe_n_r <= ~com_mask;
			seg_oe_n_r <= '0;
		end
	end

	assign rdata = rdata_r;
	assign com_lvl = com_lvl_r;
	assign seg_lvl = seg_lvl_r;
	assign com_oe_n = com_oe_n_r;
	assign seg_oe_n = seg_oe_n_r;
	assign lcd_active = lcd_on;
	assign waveform_type_b = waveform_type;
	assign bias_scheme_c = bias_scheme_sel;
	assign c_power_source_sel = main_ctl_r[MC_CPWR_LSB +: 2];
	assign r_bias_current_sel = main_ctl_r[MC_IS_LSB +: 2];
	assign r_supply_internal = r_supply_sel;
	// Pump is only worth running with the panel actually driven
	assign r_pump_en = r_supply_sel && !bias_scheme_sel && lcd_on;
	assign r_pump_voltage_sel = pump_sel_r[PS_VS_LSB +: 2];
	assign c_pump_en = bias_scheme_sel && lcd_on;
	assign bias_quarter = quarter_eff;
	assign com_count = com_n;
endmodule : lcdc_ctrl
`default_nettype wire

// >>> core/lcdc_pkg.sv
package lcdc_pkg;
	localparam int unsigned SEG_MAX = 44;
	localparam logic [2:0] DM_SECTOR = 3'h4;
	localparam logic [7:0] DM_LAST_SMALL = 8'h1D;
	localparam logic [7:0] DM_LAST_LARGE = 8'h2B;
	localparam logic [1:0] REG_MAIN_IDX = 2'h0;
	localparam logic [1:0] REG_PUMP_IDX = 2'h1;
	localparam logic [1:0] REG_CLKDUTY_IDX = 2'h2;
	localparam int unsigned MC_TYPE_BIT = 7;
	localparam int unsigned MC_RCT_BIT = 6;
	localparam int unsigned MC_CPWR_LSB = 4;
	localparam int unsigned MC_IS_LSB = 1;
	localparam int unsigned MC_EN_BIT = 0;
	localparam int unsigned PS_RSUP_BIT = 3;
	localparam int unsigned PS_VS_LSB = 0;
	localparam int unsigned CD_PCK_LSB = 5;
	localparam int unsigned CD_DUTY_LSB = 1;
	localparam int unsigned CD_BIAS_BIT = 0;
	localparam logic [7:0] MC_WMASK = 8'hF7;
	localparam logic [7:0] PS_WMASK = 8'h0B;
	localparam logic [7:0] CD_WMASK = 8'hE7;
	localparam logic [7:0] MC_RESET = 8'h00;
	localparam logic [7:0] PS_RESET = 8'h00;
	localparam logic [7:0] CD_RESET = 8'h00;
	localparam logic [2:0] LCD_DIV_LAST = 3'h7;
	localparam logic [6:0] PUMP_HALF_MAX = 7'h40;
	localparam logic [2:0] PUMP_CODE_LAST = 3'h6;
	localparam logic [1:0] DUTY_4 = 2'h0;
	localparam logic [1:0] DUTY_6 = 2'h1;
	localparam logic [1:0] DUTY_8 = 2'h2;
	typedef enum logic [1:0] {
		MODE_FAST = 2'h0,
		MODE_SLOW = 2'h1,
		MODE_IDLE = 2'h3,
		MODE_SLEEP = 2'h2
	} lcdc_mode_t;

	function automatic logic [3:0] lcdc_com_count(input logic [1:0] duty, input logic c_type);
		if (duty == DUTY_8 && !c_type) begin
			lcdc_com_count = 4'h8;
		end else if (duty == DUTY_6) begin
			lcdc_com_count = 4'h6;
		end else begin
			lcdc_com_count = 4'h4;
		end
	endfunction : lcdc_com_count

	function automatic logic [7:0] lcdc_com_mask(input logic [3:0] count);
		case (count)
			4'h8: lcdc_com_mask = 8'hFF;
			4'h6: lcdc_com_mask = 8'h3F;
			default: lcdc_com_mask = 8'h0F;
		endcase
	endfunction : lcdc_com_mask
endpackage : lcdc_pkg

// >>> verification/lcdc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_ctrl_assertions #(
	parameter int unsigned NUM_SEG = 44
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire lcdc_pkg::lcdc_mode_t op_mode,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic [23:0] com_lvl,
	input wire logic [3*NUM_SEG-1:0] seg_lvl,
	input wire logic lcd_active,
	input wire logic bias_scheme_c,
	input wire logic r_supply_internal,
	input wire logic r_pump_en,
	input wire logic c_pump_en,
	input wire logic c_pump_clk,
	input wire logic bias_quarter,
	input wire logic [3:0] com_count
);
	import lcdc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sleep_blanks_a: assert property (op_mode == MODE_SLEEP |-> !lcd_active)
		else $error("display active in sleep");
	r_pump_gate_a: assert property (r_pump_en == (r_supply_internal && !bias_scheme_c && lcd_active))
		else $error("r pump enable wrong");
	c_pump_auto_a: assert property (c_pump_en == (bias_scheme_c && lcd_active))
		else $error("c pump enable wrong");
	pump_clk_idle_a: assert property (!c_pump_en [*2] |-> !c_pump_clk)
		else $error("pump clock runs while off");
	quarter_valid_a: assert property (bias_quarter |-> !bias_scheme_c && com_count == 4'h8)
		else $error("quarter bias outside r eight com");
	duty_count_a: assert property (com_count inside {4'h4, 4'h6, 4'h8} && (!bias_scheme_c || com_count != 4'h8))
		else $error("bad com count");
	reset_low_a: assert property (!lcd_active [*2] |-> com_lvl == 24'h0 && seg_lvl == '0)
		else $error("levels not low while off");
	rdata_hold_a: assert property (!$past(rd_en) |-> $stable(rdata))
		else $error("read data moved without read");
	cover property (lcd_active && com_count == 4'h6);
	cover property ($rose(c_pump_clk));
	cover property (bias_quarter);
	cover property (r_pump_en);
endmodule : lcdc_ctrl_assertions
bind lcdc_ctrl lcdc_ctrl_assertions #(.NUM_SEG(NUM_SEG)) u_chk (.ref_clk, .rst, .op_mode, .rd_en,
	.rdata, .com_lvl, .seg_lvl, .lcd_active, .bias_scheme_c, .r_supply_internal, .r_pump_en,
	.c_pump_en, .c_pump_clk, .bias_quarter, .com_count);
`default_nettype wire

// >>> verification/lcdc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_ctrl_tb;
	import lcdc_pkg::*;
	localparam int unsigned NS = 30;
	logic ref_clk = 0, rst = 1, fsub_in = 0, dm_sel = 0, sfr_sel = 0, wr_en = 0, rd_en = 0;
	lcdc_mode_t op_mode = MODE_FAST;
	logic [2:0] dm_sector = 3'h4;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, com_oe_n, m, p, c, pat;
	logic [23:0] com_lvl;
	logic [3*NS-1:0] seg_lvl;
	logic [NS-1:0] seg_oe_n;
	logic lcd_active, waveform_type_b, bias_scheme_c, r_supply_internal, r_pump_en, c_pump_en;
	logic c_pump_clk, bias_quarter, act, pixel_on, rd_seen = 0, v;
	logic [1:0] c_power_source_sel, r_bias_current_sel, r_pump_voltage_sel;
	logic [3:0] com_count, slot, prev;
	logic [31:0] seed = 32'h3C;
	logic [7:0] expq[$];
	int errors = 0, check_count = 0, n, gap, seen, h;
	lcdc_ctrl #(.NUM_SEG(NS)) u_dut (.ref_clk, .rst, .op_mode, .fsub_in, .dm_sector, .dm_sel,
		.sfr_sel, .addr, .wr_en, .rd_en, .wdata, .rdata, .com_lvl, .com_oe_n, .seg_lvl, .seg_oe_n,
		.lcd_active, .waveform_type_b, .bias_scheme_c, .c_power_source_sel, .r_bias_current_sel,
		.r_supply_internal, .r_pump_en, .r_pump_voltage_sel, .c_pump_en, .c_pump_clk,
		.bias_quarter, .com_count);
	lcdc_panel_model u_panel (.com_lvl, .com_oe_n, .seg0_lvl(seg_lvl[2:0]), .slot, .pixel_on);
	always #12.5 ref_clk = ~ref_clk;
	// Sub-clock sped up to 1/8 of ref_clk to keep the run short
	always begin
		repeat (4) @(negedge ref_clk);
		fsub_in = ~fsub_in;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [3:0] nxt(input logic [3:0] s, input int b, input int cnt);
		logic [2:0] k;
		k = (s[2:0] == 3'(cnt - 1)) ? 3'h0 : s[2:0] + 3'h1;
		if (b == 0) return s[3] ? {1'b0, k} : {1'b1, s[2:0]};
		return {s[3] ^ (k == 3'h0), k};
	endfunction : nxt
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s exp %0h seen %0h", nm, e, s);
		end
	endtask : chk
	task automatic acc(input logic d, input logic [7:0] a, input logic w, input logic [7:0] x);
		@(negedge ref_clk);
		dm_sel = d;
		sfr_sel = !d;
		addr = a;
		wdata = x;
		wr_en = w;
		rd_en = !w;
		@(negedge ref_clk);
		wr_en = 0;
		rd_en = 0;
	endtask : acc
	task automatic rd(input logic d, input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		acc(d, a, 0, 8'h00);
	endtask : rd
	task automatic print_verdict;
		if (errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	always @(posedge ref_clk) rd_seen <= rd_en;
	always @(negedge ref_clk) if (rd_seen) chk("rdata", rdata, expq.pop_front());
	initial begin
		repeat (30000) @(posedge ref_clk);
		errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(negedge ref_clk);
		chk("reset float", {com_oe_n, &seg_oe_n}, 9'h1FF);
		rst = 0;
		for (int i = 0; i < 4; i++) rd(0, 8'(i), 8'h00);
		for (int i = 0; i < 3; i++) begin
			acc(0, 8'(i), 1, 8'hFF);
			rd(0, 8'(i), i == 0 ? MC_WMASK : i == 1 ? PS_WMASK : CD_WMASK);
		end
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			op_mode = lcdc_mode_t'(seed[25:24]);
			{c, p, m} = seed[23:0];
			acc(0, 0, 1, m);
			acc(0, 1, 1, p);
			acc(0, 2, 1, c);
			act = m[0] && op_mode != MODE_SLEEP;
			n = (c[2:1] == 2'h2 && !m[6]) ? 8 : (c[2:1] == 2'h1) ? 6 : 4;
			chk("active", lcd_active, act);
			chk("fields", {waveform_type_b, bias_scheme_c, c_power_source_sel, r_bias_current_sel},
				{m[7:4], m[2:1]});
			chk("r supply", {r_supply_internal, r_pump_voltage_sel}, {p[3], p[1:0]});
			chk("pumps", {r_pump_en, c_pump_en}, {p[3] && !m[6] && act, m[6] && act});
			chk("duty", com_count, n);
			chk("quarter", bias_quarter, c[0] && n == 8);
		end
		op_mode = MODE_FAST;
		acc(0, 0, 1, 8'h00);
		acc(0, 2, 1, 8'h00);
		acc(1, 5, 1, 8'hFF);
		rd(1, 5, 8'h0F);
		acc(0, 2, 1, 8'h05);
		acc(1, 5, 1, 8'hA5);
		rd(1, 5, 8'hA5);
		rd(1, 8'(NS), 8'h00);
		dm_sector = 3'h3;
		rd(1, 5, 8'h00);
		dm_sector = 3'h4;
		for (int t = 0; t < 2; t++) begin
			seed = xs(seed);
			pat = seed[7:0];
			n = 4 + 2 * t;
			acc(0, 0, 1, 8'h00);
			acc(0, 2, 1, 8'(2 * t));
			acc(1, 0, 1, pat);
			acc(0, 0, 1, t ? 8'h81 : 8'h01);
			prev = 4'hF;
			gap = 0;
			seen = 0;
			for (int cyc = 0; cyc < 2000; cyc++) begin
				@(negedge ref_clk);
				gap++;
				if (slot !== prev) begin
					seen++;
					if (seen > 2) chk("tick gap", gap, 64);
					if (seen > 1) chk("next slot", slot, nxt(prev, t, n));
					chk("pixel", pixel_on, pat[slot[2:0]]);
					prev = slot;
					gap = 0;
				end
			end
			chk("com oe", com_oe_n, 8'(8'hFF << n));
			chk("seg oe", seg_oe_n, 0);
		end
		op_mode = MODE_SLEEP;
		repeat (3) @(negedge ref_clk);
		chk("sleep", {lcd_active, |com_lvl, |seg_lvl}, 0);
		op_mode = MODE_FAST;
		acc(0, 0, 1, 8'h41);
		for (int cd = 0; cd < 8; cd++) begin
			acc(0, 2, 1, {3'(cd), 5'h00});
			for (int e = 0; e < 3; e++) begin
				h = 0;
				v = c_pump_clk;
				while (c_pump_clk === v && h < 1000) begin
					@(negedge ref_clk);
					h++;
				end
			end
			chk("pump half", h, (64 >> (cd > 6 ? 6 : cd)) * 8);
		end
		print_verdict();
	end
endmodule : lcdc_ctrl_tb
`default_nettype wire

// >>> verification/lcdc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_panel_model (
	input wire logic [23:0] com_lvl,
	input wire logic [7:0] com_oe_n,
	input wire logic [2:0] seg0_lvl,
	output logic [3:0] slot,
	output logic pixel_on
);
	// Bit 3 marks negative phase; 4'hF when no COM is selected
	logic has2;
	always_comb begin
		slot = 4'hF;
		has2 = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if (!com_oe_n[k] && com_lvl[3*k+:3] == 3'h2) has2 = 1'b1;
		end
		for (int k = 0; k < 8; k++) begin
			if (!com_oe_n[k] && com_lvl[3*k+:3] == 3'h3) slot = {1'b0, 3'(k)};
			if (!com_oe_n[k] && com_lvl[3*k+:3] == 3'h0 && has2) slot = {1'b1, 3'(k)};
		end
		pixel_on = slot[3] ? (seg0_lvl == 3'h3) : (seg0_lvl == 3'h0);
	end
endmodule : lcdc_panel_model
`default_nettype wire
